// ===== hw/sensor_bus.sv
/*
 * Sensor drive, line timing and binary image bus (serial or packed parallel).
 * Assumes 100 MHz clk; pins from outside pass two flops; pixels arrive on clk.
 */
// Notes on behaviour
// - line sync pin is input in slave mode, output when master and sync select set
// - master mode with sync select clear copies master clock to its output pin
// - ccd type gives two half-rate phase clocks, otherwise full-rate shift clock
// - gate pin carries shift gate for ccd, else bipolar or photocell begin pulse
// - reset mode clear gives alternating reset clocks, set gives reset and sample clocks
// - timing selector picks offset, gain, user all lines or user valid lines
// - overflow gain outputs low ask for less gain, high for more
// - offset window high while sampling, low while holding
// - gain window high while adjusting, low while holding
// - trigger scan: low request forces begin pulse low, then line shifts out
// - cycle scan: low request enables the next line, which then shifts out
// - free scan ignores request, lines start on the period and all shift out
// - parallel mode: transfer request low when a byte waits, high otherwise
// - serial mode: shared pin is video enable, low while serial data valid
// - video serial clock runs in both modes to time serial data
// - serial data low for black, high for white
// - parallel data driven while acknowledge low, released while high
// - packed byte holds up to eight pixels, 1 black, first pixel in msb
`timescale 1ns/1ps
`include "sensor_bus_regs.svh"
module sensor_bus
    import sensor_bus_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic master_clock_in,
    output logic master_clock_out,
    input wire logic master_select,
    input wire logic sync_pin_select,
    input wire logic line_sync_n_in,
    output logic line_sync_n_out,
    output logic line_sync_oe_n,
    input wire mem_t mem_mode,
    input wire scan_t scan_mode,
    input wire logic [15:0] line_period,
    input wire logic [15:0] user_start,
    input wire logic [15:0] user_end,
    input wire logic sensor_type_select,
    input wire logic contact_type_select,
    input wire logic reset_mode_select,
    input wire logic timing_select_high,
    input wire logic timing_select_low,
    output logic phase_one_clock,
    output logic phase_two_clock,
    output logic sensor_gate,
    output logic reset_clock_one,
    output logic reset_clock_two,
    output logic sensor_timing_out,
    input wire logic over_one,
    input wire logic over_two,
    output logic overflow_gain_one,
    output logic overflow_gain_two,
    output logic offset_window,
    output logic gain_adjust_window,
    input wire logic pixel_valid,
    output logic pixel_ready,
    input wire logic pixel_white,
    input wire logic pixel_last,
    input wire logic parallel_interface_select,
    input wire logic video_request_n,
    input wire logic transfer_acknowledge_n,
    output logic request_or_enable_n,
    output logic video_serial_clock,
    output logic video_serial_data,
    output logic [7:0] parallel_image_data,
    output logic parallel_image_data_oe_n
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] mck_s;
    logic [2:0] sync_s;
    logic [2:0] req_s;
    logic [2:0] ack_s;
    logic [4:0] half_cnt_r;
    logic ck_r;
    logic half_r;
    logic mclk_rise;
    logic half_tick;
    logic pix_tick;
    logic [4:0] half_len;

    // two flops then an edge flop; only stage 1 and 2 are read by logic
    always_ff @(posedge clk) begin
        if (srst) begin
            mck_s <= '0;
            sync_s <= '1;
            req_s <= '1;
            ack_s <= '1;
        end else begin
            mck_s <= {mck_s[1:0], master_clock_in};
            sync_s <= {sync_s[1:0], line_sync_n_in};
            req_s <= {req_s[1:0], video_request_n};
            ack_s <= {ack_s[1:0], transfer_acknowledge_n};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // image clock from master clock edges
    function automatic logic [4:0] half_of(input mem_t m);
        case (m)
            MEM_L: half_of = `HALF_L;
            MEM_M: half_of = `HALF_M;
            default: half_of = `HALF_H;
        endcase
    endfunction

    assign half_len = half_of(mem_mode);
    assign mclk_rise = mck_s[1] & ~mck_s[2];
    assign half_tick = mclk_rise && (half_cnt_r >= half_len - 5'h01); // copes with mode change
    assign pix_tick = half_tick & ck_r; // image clock falls here
    // half period counter, image clock level and ccd half-rate phase
    always_ff @(posedge clk) begin
        if (srst) begin
            half_cnt_r <= '0;
            ck_r <= 1'b0;
            half_r <= 1'b0;
        end else if (mclk_rise) begin
            half_cnt_r <= half_tick ? 5'h00 : half_cnt_r + 5'h01;
            if (half_tick) begin
                ck_r <= ~ck_r;
                half_r <= half_r ^ ck_r;
            end
        end
    end

    // master clock copy onto its output pin in master mode with sync select clear
    always_ff @(posedge clk) begin
        if (srst) begin
            master_clock_out <= 1'b0;
        end else begin
            master_clock_out <= mck_s[1] & master_select & ~sync_pin_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line timing and scan modes
    logic [15:0] pos_r;
    logic armed_r;
    logic line_valid_r;
    logic line_start;
    logic req_fall;
    logic wrap;
    logic begin_on;
    assign req_fall = ~req_s[1] & req_s[2];
    assign wrap = pix_tick && (pos_r >= line_period - 16'h0001);

    // line start source: sync pin in slave mode, own timing in master mode except request fall in trigger scan
    always_comb begin
        line_start = 1'b0;
        if (!master_select) begin
            line_start = ~sync_s[1] & sync_s[2];
        end else begin
            case (scan_mode)
                SCAN_FREE: line_start = wrap;
                SCAN_CYCLE: line_start = wrap & armed_r;
                SCAN_TRIGGER: line_start = req_fall;
                default: line_start = wrap;
            endcase
        end
    end

    // position counter and request latch; a new request wins over the clear
    always_ff @(posedge clk) begin
        if (srst) begin
            pos_r <= 16'hffff;
            armed_r <= 1'b0;
            line_valid_r <= 1'b0;
        end else begin
            if (line_start) begin
                pos_r <= 16'h0000;
                line_valid_r <= (scan_mode != SCAN_CYCLE) | armed_r;
            end else if (pix_tick && pos_r != 16'hffff) begin
                pos_r <= pos_r + 16'h0001;
            end
            if (~req_s[1]) begin
                armed_r <= 1'b1;
            end else if (line_start) begin
                armed_r <= 1'b0;
            end
        end
    end

    assign begin_on = (pos_r < `BEGIN_LEN);

    ////////////////////////////////////////////////////////////////////////
    // sensor drive pins
    logic ofs_on;
    logic gain_on;
    logic user_on;
    assign ofs_on = (pos_r >= `OFS_START) && (pos_r <= `OFS_END);
    assign gain_on = (pos_r >= `GAIN_START) && (pos_r <= `GAIN_END);
    assign user_on = (pos_r >= user_start) && (pos_r <= user_end);

    // registered drive outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_one_clock <= 1'b0;
            phase_two_clock <= 1'b0;
            sensor_gate <= 1'b0;
            reset_clock_one <= 1'b0;
            reset_clock_two <= 1'b0;
            sensor_timing_out <= 1'b0;
            offset_window <= 1'b0;
            gain_adjust_window <= 1'b0;
            overflow_gain_one <= 1'b1;
            overflow_gain_two <= 1'b1;
            line_sync_n_out <= 1'b1;
            line_sync_oe_n <= 1'b1;
        end else begin
            if (sensor_type_select) begin
                phase_one_clock <= half_r;
                phase_two_clock <= ~half_r;
                sensor_gate <= begin_on;
            end else begin
                phase_one_clock <= ck_r;
                phase_two_clock <= ck_r;
                sensor_gate <= contact_type_select ? ~begin_on : begin_on;
            end
            if (!reset_mode_select) begin
                reset_clock_one <= ck_r & half_r;
                reset_clock_two <= ck_r & ~half_r;
            end else begin
                reset_clock_one <= ck_r;
                reset_clock_two <= ~ck_r;
            end
            case ({timing_select_high, timing_select_low})
                2'b00: sensor_timing_out <= ofs_on;
                2'b01: sensor_timing_out <= gain_on;
                2'b10: sensor_timing_out <= user_on;
                default: sensor_timing_out <= user_on & line_valid_r;
            endcase
            offset_window <= ofs_on;
            gain_adjust_window <= gain_on;
            overflow_gain_one <= ~(gain_on & over_one);
            overflow_gain_two <= ~(gain_on & over_two);
            line_sync_n_out <= ~begin_on;
            line_sync_oe_n <= ~(master_select & sync_pin_select);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pixel fifo: back-pressure reaches the pixel source
    logic f_valid;
    logic f_ready;
    logic [1:0] f_data;
    logic pop;
    logic last_r;
    logic sen_r;
    logic byte_full_r;
    logic [2:0] bit_cnt_r;
    logic [6:0] pack_r;
    logic ack_seen_r;

    pixel_fifo #(
        .WIDTH(`PIX_FIFO_WIDTH),
        .DEPTH(`PIX_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .s_valid(pixel_valid),
        .s_ready(pixel_ready),
        .s_data({pixel_last, pixel_white}),
        .m_valid(f_valid),
        .m_ready(f_ready),
        .m_data(f_data)
    );

    // one pixel per image clock; a gap follows each line end
    assign pop = pix_tick & f_valid & ~last_r & ~(parallel_interface_select & byte_full_r);
    assign f_ready = pop;

    ////////////////////////////////////////////////////////////////////////
    // serial output, shared request/enable pin and parallel packing
    always_ff @(posedge clk) begin
        if (srst) begin
            sen_r <= 1'b0;
            last_r <= 1'b0;
            video_serial_data <= 1'b1;
        end else if (pop) begin
            sen_r <= 1'b1;
            last_r <= f_data[1];
            video_serial_data <= f_data[0];
        end else if (pix_tick & last_r) begin
            sen_r <= 1'b0;
            last_r <= 1'b0;
        end
    end

    // clock idles high, runs while a line shifts
    assign video_serial_clock = ~sen_r | ck_r;

    // byte packing; the acknowledge rising edge releases the byte
    always_ff @(posedge clk) begin
        if (srst) begin
            byte_full_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            pack_r <= 7'h00;
            parallel_image_data <= 8'h00;
            ack_seen_r <= 1'b0;
        end else begin
            if (pop & parallel_interface_select) begin
                pack_r <= {pack_r[5:0], ~f_data[0]};
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == 3'h7 || f_data[1]) begin
                    parallel_image_data <= {pack_r, ~f_data[0]} << (3'h7 - bit_cnt_r);
                    byte_full_r <= 1'b1;
                    bit_cnt_r <= 3'h0;
                end
            end else if (byte_full_r & ack_seen_r & ack_s[1]) begin
                byte_full_r <= 1'b0;
            end
            ack_seen_r <= byte_full_r & ~ack_s[1];
        end
    end

    // shared pin and data enables
    always_ff @(posedge clk) begin
        if (srst) begin
            request_or_enable_n <= 1'b1;
            parallel_image_data_oe_n <= 1'b1;
        end else if (parallel_interface_select) begin
            request_or_enable_n <= ~byte_full_r | ack_seen_r;
            parallel_image_data_oe_n <= ack_s[1];
        end else begin
            request_or_enable_n <= ~sen_r;
            parallel_image_data_oe_n <= 1'b1;
        end
    end
endmodule // sensor_bus

// ===== hw/sensor_bus_regs.svh
/*
 * Timing counts and window positions for the sensor drive and image bus block.
 * Assumes the includer counts positions in image clock periods from line start.
 */
`ifndef SENSOR_BUS_REGS_SVH
`define SENSOR_BUS_REGS_SVH
// master clock rising edges per half image clock, per memory mode
`define HALF_L 5'h08
`define HALF_M 5'h04
`define HALF_H 5'h01
// begin and shift gate pulse length, image clocks
`define BEGIN_LEN 16'h0004
// offset sample window
`define OFS_START 16'h0008
`define OFS_END 16'h0028
// gain adjust window
`define GAIN_START 16'h0030
`define GAIN_END 16'h00c8
// fifo shape in the pixel path
`define PIX_FIFO_DEPTH 8
`define PIX_FIFO_WIDTH 2
`endif

// ===== hw/sensor_bus_pkg.sv
/*
 * Types shared by the sensor drive and image bus block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sensor_bus_pkg;
    typedef enum logic [1:0] {SCAN_FREE, SCAN_CYCLE, SCAN_TRIGGER, SCAN_SPARE} scan_t;
    typedef enum logic [1:0] {MEM_L, MEM_M, MEM_H, MEM_T} mem_t;
endpackage

// ===== hw/pixel_fifo.sv
/*
 * Small synchronous fifo with valid/ready on both sides.
 * Assumes one clock and a synchronous active high reset.
 */
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    // honest full and empty from the fill count
    assign s_ready = (cnt_r != (AW+1)'(DEPTH));
    assign m_valid = (cnt_r != '0);
    assign push = s_valid & s_ready;
    assign pop = m_valid & m_ready;
    assign m_data = mem[rp_r];

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= s_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk) begin
        if (srst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // pixel_fifo

// ===== bench/sensor_bus_asserts.sv
/* concurrent checks on the sensor_bus ports
   assumes a bind onto sensor_bus, one clock, srst synchronous */
`timescale 1ns/1ps
module sensor_bus_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic master_select,
    input wire logic sync_pin_select,
    input wire logic master_clock_out,
    input wire logic line_sync_oe_n,
    input wire logic sensor_type_select,
    input wire logic phase_one_clock,
    input wire logic phase_two_clock,
    input wire logic timing_select_high,
    input wire logic timing_select_low,
    input wire logic sensor_timing_out,
    input wire logic over_one,
    input wire logic overflow_gain_one,
    input wire logic offset_window,
    input wire logic gain_adjust_window,
    input wire logic parallel_interface_select,
    input wire logic transfer_acknowledge_n,
    input wire logic request_or_enable_n,
    input wire logic video_serial_clock,
    input wire logic video_serial_data,
    input wire logic parallel_image_data_oe_n
);
    logic [1:0] tsel;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    // selector pair seen as one field
    assign tsel = {timing_select_high, timing_select_low};
    // pin routing by master and sync select
    AST_MCLK_OFF: assert property (
        (!master_select || sync_pin_select) [*2] |-> !master_clock_out)
        else $error("master clock out active outside master mode");
    AST_SYNC_DRIVE: assert property (
        (master_select && sync_pin_select) [*2] |-> !line_sync_oe_n)
        else $error("line sync pin not driven in master mode");
    AST_SYNC_FREE: assert property (
        !master_select [*2] |-> line_sync_oe_n)
        else $error("line sync pin driven in slave mode");
    // sensor clocks and timing selector
    AST_SHIFT_CLK: assert property (
        !sensor_type_select [*2] |-> phase_one_clock == phase_two_clock)
        else $error("shift clock pins differ");
    AST_TIM_OFS: assert property (
        (tsel == 2'b00) [*3] ##0 $rose(offset_window) |-> ##[0:1] sensor_timing_out)
        else $error("timing pin misses offset window");
    AST_TIM_GAIN: assert property (
        (tsel == 2'b01) [*3] ##0 $rose(gain_adjust_window) |-> ##[0:1] sensor_timing_out)
        else $error("timing pin misses gain window");
    // analog loop windows and gain request
    AST_GAIN_REQ: assert property (
        $fell(overflow_gain_one) |-> $past(over_one))
        else $error("gain reduce without overflow");
    AST_OFS_LEN: assert property (
        $rose(offset_window) |-> offset_window [*8])
        else $error("offset window too short");
    AST_WIN_EXCL: assert property (
        !(offset_window && gain_adjust_window))
        else $error("offset and gain windows overlap");
    // image bus pins
    AST_DATA_REL: assert property (
        transfer_acknowledge_n [*5] |-> parallel_image_data_oe_n)
        else $error("parallel data driven without acknowledge");
    AST_SER_IDLE: assert property (
        (!parallel_interface_select && request_or_enable_n) [*3] |-> $past(video_serial_clock))
        else $error("serial clock not idle high");
    AST_SER_EDGE: assert property (
        $changed(video_serial_data) |-> !video_serial_clock)
        else $error("serial data changed while clock high");
endmodule // sensor_bus_asserts
bind sensor_bus sensor_bus_asserts i_sensor_bus_asserts (.clk, .srst, .master_select,
    .sync_pin_select, .master_clock_out, .line_sync_oe_n, .sensor_type_select,
    .phase_one_clock, .phase_two_clock, .timing_select_high, .timing_select_low,
    .sensor_timing_out, .over_one, .overflow_gain_one, .offset_window,
    .gain_adjust_window, .parallel_interface_select, .transfer_acknowledge_n,
    .request_or_enable_n, .video_serial_clock, .video_serial_data,
    .parallel_image_data_oe_n);

// ===== bench/video_sink.sv
/* far-end image controller: request pin and parallel byte acknowledge
   assumes the block's clk; captured bytes kept in a queue */
`timescale 1ns/1ps
module video_sink (
    input wire logic clk,
    input wire logic want_line,
    input wire logic [3:0] ack_wait,
    input wire logic request_or_enable_n,
    input wire logic parallel_interface_select,
    input wire logic [7:0] parallel_image_data,
    input wire logic parallel_image_data_oe_n,
    output logic video_request_n,
    output logic transfer_acknowledge_n
);
    logic [7:0] bytes_q[$];
    int i;
    ////////////////////////////////////////
    // request pin follows the bench's wish
    initial video_request_n = 1'b1;
    always @(posedge clk) video_request_n <= !want_line;
    // answer each transfer request after a chosen stall
    initial begin
        transfer_acknowledge_n = 1'b1;
        forever begin
            @(posedge clk);
            if (parallel_interface_select && !request_or_enable_n) begin
                repeat (ack_wait) @(posedge clk);
                transfer_acknowledge_n <= 1'b0;
                for (i = 0; i < 50 && parallel_image_data_oe_n; i++) @(posedge clk);
                bytes_q.push_back(parallel_image_data);
                @(posedge clk);
                transfer_acknowledge_n <= 1'b1;
                repeat (4) @(posedge clk);
            end
        end
    end
endmodule // video_sink

// ===== bench/tb.sv
/* self-checking bench for sensor_bus with random pixels
   assumes video_sink as far end and the bound checker */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb
    import sensor_bus_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, master_clock_in = 1'b0, master_select = 1'b0;
    logic sync_pin_select = 1'b0, sensor_type_select = 1'b1, contact_type_select = 1'b0;
    logic reset_mode_select = 1'b0, timing_select_high = 1'b0, timing_select_low = 1'b0;
    logic over_one = 1'b0, over_two = 1'b0, pixel_valid = 1'b0, pixel_white = 1'b0;
    logic pixel_last = 1'b0, parallel_interface_select = 1'b0, want_line = 1'b0;
    mem_t mem_mode = MEM_H;
    scan_t scan_mode = SCAN_FREE;
    logic [15:0] line_period = 16'h00d2, user_start = 16'h0010, user_end = 16'h0020;
    logic [3:0] ack_wait = 4'h0;
    logic line_sync_n_in, master_clock_out, line_sync_n_out, line_sync_oe_n, phase_one_clock;
    logic phase_two_clock, sensor_gate, reset_clock_one, reset_clock_two, sensor_timing_out;
    logic overflow_gain_one, overflow_gain_two, offset_window, gain_adjust_window, pixel_ready;
    logic request_or_enable_n, video_serial_clock, video_serial_data, parallel_image_data_oe_n;
    logic video_request_n, transfer_acknowledge_n, rdy_s, vck_p, en_p, hi, saw_full;
    logic cap_on = 1'b0, sync_drv_n = 1'b1;
    logic [7:0] parallel_image_data;
    logic pq[$], sq[$];
    int seed, fail_count, tests_run, en_falls, k, n;
    scan_t smode[5] = '{SCAN_FREE, SCAN_CYCLE, SCAN_TRIGGER, SCAN_TRIGGER, SCAN_CYCLE};
    logic wreq[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic egate[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    ////////////////////////////////////////
    // line sync wire: the far end drives it (idle high) unless the block does
    assign line_sync_n_in = line_sync_oe_n ? sync_drv_n : line_sync_n_out;
    // released parallel data pins read back inverted, so a late sample shows up
    wire [7:0] vpd_bus = parallel_image_data_oe_n ? ~parallel_image_data : parallel_image_data;
    sensor_bus i_sensor_bus (.clk, .srst, .master_clock_in, .master_clock_out, .master_select,
        .sync_pin_select, .line_sync_n_in, .line_sync_n_out, .line_sync_oe_n, .mem_mode,
        .scan_mode, .line_period, .user_start, .user_end, .sensor_type_select,
        .contact_type_select, .reset_mode_select, .timing_select_high, .timing_select_low,
        .phase_one_clock, .phase_two_clock, .sensor_gate, .reset_clock_one, .reset_clock_two,
        .sensor_timing_out, .over_one, .over_two, .overflow_gain_one, .overflow_gain_two,
        .offset_window, .gain_adjust_window, .pixel_valid, .pixel_ready, .pixel_white,
        .pixel_last, .parallel_interface_select, .video_request_n, .transfer_acknowledge_n,
        .request_or_enable_n, .video_serial_clock, .video_serial_data, .parallel_image_data,
        .parallel_image_data_oe_n);
    video_sink i_video_sink (.clk, .want_line, .ack_wait, .request_or_enable_n,
        .parallel_interface_select, .parallel_image_data(vpd_bus), .parallel_image_data_oe_n,
        .video_request_n, .transfer_acknowledge_n);
    // system clock and free-running master clock of unrelated phase
    initial forever #5 clk = ~clk;
    initial begin
        #37;
        forever #80 master_clock_in = ~master_clock_in;
    end
    // ready as seen before each edge; random overflow flags
    always @(negedge clk) rdy_s = pixel_ready;
    always @(posedge clk) begin
        over_one <= 1'($random(seed));
        over_two <= 1'($random(seed));
    end
    // serial capture on rising video clock while enable is low
    always @(posedge clk) begin
        vck_p <= video_serial_clock;
        en_p <= request_or_enable_n;
        if (cap_on && !request_or_enable_n && video_serial_clock && !vck_p)
            sq.push_back(video_serial_data);
        if (cap_on && en_p && !request_or_enable_n)
            en_falls++;
    end
    function automatic logic [7:0] exp_byte(input int s, input int cnt);
        exp_byte = 8'h00;
        for (int j = 0; j < cnt; j++) exp_byte[7 - j] = !pq[s + j];
    endfunction
    task automatic send_line(input int cnt);
        logic w;
        int m;
        pq.delete();
        sq.delete();
        saw_full = 1'b0;
        pixel_valid <= 1'b1;
        for (int i = 0; i < cnt; i++) begin
            w = 1'($random(seed));
            pq.push_back(w);
            pixel_white <= w;
            pixel_last <= (i == cnt - 1);
            m = 0;
            do begin
                @(posedge clk);
                m++;
                saw_full = saw_full | !rdy_s;
            end while (!rdy_s && m < 2000);
        end
        pixel_valid <= 1'b0;
    endtask
    task automatic wait_gate(output logic got);
        logic p;
        p = sensor_gate;
        got = 1'b0;
        for (int i = 0; i < 7200 && !got; i++) begin
            @(posedge clk);
            got = sensor_gate && !p;
            p = sensor_gate;
        end
    endtask
    task note(input string s);
        $display("test %s done", s);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // hang guard
    initial begin
        #900000;
        fail_count++;
        $display("[ERR] watchdog exp done got hang");
        print_verdict();
    end
    // main sequence
    initial begin
        seed = 32'h318e7e5c;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("gain_one", 1'b1, overflow_gain_one)
        `CHK("gain_two", 1'b1, overflow_gain_two)
        `CHK("enable_n", 1'b1, request_or_enable_n)
        `CHK("ser_data", 1'b1, video_serial_data)
        note("reset");
        for (k = 0; k < 3; k++) begin
            master_select <= (k != 0);
            sync_pin_select <= (k == 2);
            repeat (4) @(posedge clk);
            hi = 1'b0;
            repeat (40) begin
                @(posedge clk);
                hi = hi | master_clock_out;
            end
            `CHK("mclk_out", (k == 1), hi)
            `CHK("sync_oe_n", (k != 2), line_sync_oe_n)
        end
        note("pins");
        for (k = 0; k < 5; k++) begin
            scan_mode <= smode[k];
            want_line <= wreq[k];
            {reset_mode_select, timing_select_high, timing_select_low} <= 3'($random(seed));
            @(posedge clk);
            wait_gate(hi);
            `CHK("line_start", egate[k], hi)
            `CHK("sync_out", !hi, line_sync_n_out)
            hi = reset_mode_select ? reset_clock_one ^ reset_clock_two
                : reset_clock_one & reset_clock_two;
            `CHK("rst_pair", reset_mode_select, hi)
        end
        // slave mode: the far end pulls the line sync pin low once
        master_select <= 1'b0;
        repeat (200) @(posedge clk);
        sync_drv_n <= 1'b0;
        repeat (2) @(posedge clk);
        sync_drv_n <= 1'b1;
        wait_gate(hi);
        `CHK("slave_line", 1'b1, hi)
        master_select <= 1'b1;
        note("scan");
        scan_mode <= SCAN_FREE;
        {timing_select_high, timing_select_low} <= 2'b00;
        mem_mode <= MEM_M;
        sensor_type_select <= 1'b0;
        contact_type_select <= 1'($random(seed));
        cap_on = 1'b1;
        send_line(12);
        for (n = 0; n < 4000 && sq.size() < 12; n++) @(posedge clk);
        for (n = 0; n < 400 && !request_or_enable_n; n++) @(posedge clk);
        `CHK("bit_count", 12, sq.size())
        for (n = 0; n < 12; n++) `CHK("ser_bit", pq[n], sq[n])
        `CHK("en_falls", 1, en_falls)
        `CHK("full_seen", 1'b1, saw_full)
        cap_on = 1'b0;
        note("serial");
        timing_select_low <= 1'b1;
        mem_mode <= MEM_H;
        parallel_interface_select <= 1'b1;
        ack_wait <= 4'($random(seed));
        send_line(12);
        for (n = 0; n < 3000 && i_video_sink.bytes_q.size() < 2; n++) @(posedge clk);
        repeat (8) @(posedge clk);
        `CHK("byte_count", 2, i_video_sink.bytes_q.size())
        `CHK("byte0", exp_byte(0, 8), i_video_sink.bytes_q[0])
        `CHK("byte1", exp_byte(8, 4), i_video_sink.bytes_q[1])
        `CHK("data_oe_n", 1'b1, parallel_image_data_oe_n)
        `CHK("parallel_transfer_request_idle", 1'b1, request_or_enable_n)
        wait_gate(hi);
        `CHK("free_line", 1'b1, hi)
        note("parallel");
        print_verdict();
    end
endmodule // tb
